// ---- wdog_pkg.sv ----
// Shared constants and types of the feed-sequenced watchdog.
// Assumes a single 100 MHz bus clock; the counting clock arrives as an enable pulse.
`default_nettype none
package wdog_pkg;

  // ********************************************************************
  // Register map
  // ********************************************************************
  localparam logic [11:0] OFF_MODE_CONTROL    = 12'h000;
  localparam logic [11:0] OFF_TIMEOUT_CONST   = 12'h004;
  localparam logic [11:0] OFF_FEED_PORT       = 12'h008;
  localparam logic [11:0] OFF_COUNT_READBACK  = 12'h00c;

  // Mode control bit positions
  localparam int unsigned BIT_RUN_ENABLE       = 0;
  localparam int unsigned BIT_RESET_ON_TIMEOUT = 1;
  localparam int unsigned BIT_TIMEOUT_FLAG     = 2;
  localparam int unsigned BIT_INTERRUPT_FLAG   = 3;

  // ********************************************************************
  // Values and timing
  // ********************************************************************
  localparam logic [7:0]  FEED_KEY_FIRST   = 8'haa;
  localparam logic [7:0]  FEED_KEY_SECOND  = 8'h55;
  localparam logic [23:0] TIMEOUT_MIN      = 24'h00_00ff;
  localparam logic [23:0] TIMEOUT_RESET    = 24'h00_00ff;
  localparam logic [23:0] COUNT_RESET      = 24'h00_00ff;
  localparam logic [1:0]  PRESCALE_LAST    = 2'h3;
  localparam int unsigned TIMEOUT_WIDTH    = 24;

  // ********************************************************************
  // Types
  // ********************************************************************
  typedef enum logic [0:0] {
    FEED_IDLE        = 1'b0,
    FEED_AFTER_FIRST = 1'b1
  } feed_state_t;

  // Mode bits as seen by the counting logic
  typedef struct packed {
    logic run;
    logic reset_mode;
  } mode_t;

  // Bus answer carried as one group
  typedef struct packed {
    logic [31:0] rdata;
    logic        ready;
    logic        slverr;
  } bus_answer_t;

endpackage

`default_nettype wire

// ---- wdog_prescaler.sv ----
// Fixed divide-by-4 prescaler of the watchdog counting clock.
// Assumes count_en_in is a one-cycle pulse per counting-clock period.
`timescale 1ns/1ps
`default_nettype none

module wdog_prescaler (
  input  wire logic clock_in,
  input  wire logic rst_in,
  input  wire logic count_en_in,
  output logic      tick_out
);

  typedef struct packed {
    logic [1:0] phase;
  } presc_state_t;

  presc_state_t s_r;
  presc_state_t s_nxt;

  // ********************************************************************
  // Divider
  // ********************************************************************
  // One tick on every fourth counting-clock pulse
  always_comb begin
    s_nxt = s_r;
    if (count_en_in) begin
      s_nxt.phase = s_r.phase + 2'h1;
    end
  end

  assign tick_out = count_en_in && (s_r.phase == wdog_pkg::PRESCALE_LAST);

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule

`default_nettype wire

// ---- wdog_stage.sv ----
// Two-stage enabled register pipeline used to move words between the
// bus side and the counting side of the watchdog.
// Assumes the source word is held stable between enable pulses.
`timescale 1ns/1ps
`default_nettype none

module wdog_stage #(
  parameter int unsigned     WIDTH = 24,
  parameter logic [23:0]     INIT  = 24'h00_00ff
) (
  input  wire logic             clock_in,
  input  wire logic             rst_in,
  input  wire logic             en_in,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } stage_state_t;

  stage_state_t s_r;
  stage_state_t s_nxt;

  // ********************************************************************
  // Pipeline
  // ********************************************************************
  // Two stages so that a word never lands half-updated on the far side
  always_comb begin
    s_nxt = s_r;
    if (en_in) begin
      s_nxt.first  = d_in;
      s_nxt.second = s_r.first;
    end
  end

  assign q_out = s_r.second;

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      s_r <= {INIT[WIDTH-1:0], INIT[WIDTH-1:0]};
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule

`default_nettype wire

// ---- feed_sequenced_watchdog.sv ----
// Feed-sequenced watchdog: APB register slave, feed sequence checker,
// divide-by-4 prescaler and 24-bit down-counter with reset or interrupt.
// Assumes count_clock_en_in is a one-cycle pulse from the counting-clock
// divider on the same bus clock (low while that clock is stopped), and
// that chip_reset_in comes from the system reset controller on this clock.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Divide by four, decrement 24-bit counter
// - Counter never loaded below 0xFF
// - Timeout writes below 0xFF store 0xFF
// - Timeout constant resets to 0xFF
// - 0xAA then 0x55 reloads counter
// - Counting starts only after valid feed
// - Feed errors ignored until running
// - Wrong access after 0xAA: reset/interrupt
// - Error reset two bus cycles later
// - Mode changes act after next feed
// - Enable bits set-only, cleared by reset/underflow
// - Timeout flag survives watchdog reset
// - Interrupt flag read-only, cleared by reset
// - Interrupt mode: underflow raises interrupt
// - Reset mode: underflow resets chip
// - Interrupt request stays asserted
// - Interrupt wakes a sleeping core
// - Config reaches counting side within three
// - Readback is a staged counter snapshot
// - Counting on enable, registers on bus
module feed_sequenced_watchdog (
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  input  wire logic        chip_reset_in,
  input  wire logic        count_clock_en_in,
  input  wire logic        sleeping_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  output logic             chip_reset_req_out,
  output logic             irq_out,
  output logic             wake_out
);

  // ********************************************************************
  // State
  // ********************************************************************
  typedef struct packed {
    logic                    run_enable;
    logic                    reset_on_timeout;
    logic                    timeout_flag;
    logic                    interrupt_flag;
    logic [23:0]             timeout_constant;
    wdog_pkg::mode_t         active;
    wdog_pkg::feed_state_t   feed_state;
    logic                    reload_pend;
    logic [23:0]             counter;
    logic [23:0]             snapshot;
    logic                    err_stage;
    logic                    chip_reset;
    logic                    irq;
    logic                    wake;
    wdog_pkg::bus_answer_t   answer;
  } wd_state_t;

  wd_state_t   s_r;
  wd_state_t   s_nxt;
  logic        presc_tick;
  logic [23:0] tc_counting;
  logic [23:0] snapshot_bus;

  // ********************************************************************
  // Functions
  // ********************************************************************
  // Floor of the reload value; shared by the register write and the reload
  // Reserved high bits take no part in the compare, so they cannot smuggle a
  // short timeout past the floor
  function automatic logic [23:0] clamp_timeout(input logic [31:0] value);
    logic [23:0] result;
    result = value[23:0];
    if (value[23:0] < wdog_pkg::TIMEOUT_MIN) begin
      result = wdog_pkg::TIMEOUT_MIN;
    end
    return result;
  endfunction

  // True for any of the four mapped word addresses
  function automatic logic addr_known(input logic [11:0] addr);
    logic hit;
    hit = 1'b0;
    case (addr)
      wdog_pkg::OFF_MODE_CONTROL,
      wdog_pkg::OFF_TIMEOUT_CONST,
      wdog_pkg::OFF_FEED_PORT,
      wdog_pkg::OFF_COUNT_READBACK: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  // ********************************************************************
  // Submodules
  // ********************************************************************
  // Counting side runs only on counting-clock pulses
  wdog_prescaler u_prescaler (
    .clock_in    (clock_in),
    .rst_in      (rst_in),
    .count_en_in (count_clock_en_in),
    .tick_out    (presc_tick)
  );

  // Timeout constant handed to the counting side over two counting pulses
  wdog_stage #(
    .WIDTH (wdog_pkg::TIMEOUT_WIDTH),
    .INIT  (wdog_pkg::TIMEOUT_RESET)
  ) u_tc_stage (
    .clock_in (clock_in),
    .rst_in   (rst_in),
    .en_in    (count_clock_en_in),
    .d_in     (s_r.timeout_constant),
    .q_out    (tc_counting)
  );

  // Locked snapshot brought back over two bus cycles
  // Readback lags the counter by one counting pulse plus two bus cycles at most,
  // well inside the age that software has to allow for
  wdog_stage #(
    .WIDTH (wdog_pkg::TIMEOUT_WIDTH),
    .INIT  (wdog_pkg::COUNT_RESET)
  ) u_snap_stage (
    .clock_in (clock_in),
    .rst_in   (rst_in),
    .en_in    (1'b1),
    .d_in     (s_r.snapshot),
    .q_out    (snapshot_bus)
  );

  // ********************************************************************
  // Next state
  // ********************************************************************
  logic setup_phase;
  logic access_phase;
  logic feed_write;
  logic second_key;
  logic feed_error;
  logic valid_feed;
  logic underflow;

  // A system reset that falls between setup and access drops the prepared
  // answer; the master then waits in its access phase, so resets are expected
  // only while the bus is idle
  always_comb begin
    s_nxt        = s_r;
    setup_phase  = psel_in && !penable_in;
    access_phase = psel_in && penable_in && s_r.answer.ready;
    feed_write   = access_phase && pwrite_in && (paddr_in == wdog_pkg::OFF_FEED_PORT);
    second_key   = feed_write && (pwdata_in[7:0] == wdog_pkg::FEED_KEY_SECOND);
    valid_feed   = second_key && (s_r.feed_state == wdog_pkg::FEED_AFTER_FIRST);
    feed_error   = access_phase && (s_r.feed_state == wdog_pkg::FEED_AFTER_FIRST) && !second_key;
    underflow    = 1'b0;

    // Answer is prepared in the setup cycle so every bus output is a flop
    s_nxt.answer.ready  = setup_phase;
    s_nxt.answer.slverr = setup_phase && !addr_known(paddr_in);
    s_nxt.answer.rdata  = 32'h0000_0000;
    if (setup_phase) begin
      case (paddr_in)
        wdog_pkg::OFF_MODE_CONTROL: begin
          s_nxt.answer.rdata[wdog_pkg::BIT_RUN_ENABLE]       = s_r.run_enable;
          s_nxt.answer.rdata[wdog_pkg::BIT_RESET_ON_TIMEOUT] = s_r.reset_on_timeout;
          s_nxt.answer.rdata[wdog_pkg::BIT_TIMEOUT_FLAG]     = s_r.timeout_flag;
          s_nxt.answer.rdata[wdog_pkg::BIT_INTERRUPT_FLAG]   = s_r.interrupt_flag;
        end
        wdog_pkg::OFF_TIMEOUT_CONST:  s_nxt.answer.rdata[23:0] = s_r.timeout_constant;
        wdog_pkg::OFF_COUNT_READBACK: s_nxt.answer.rdata[23:0] = snapshot_bus;
        default:                      s_nxt.answer.rdata = 32'h0000_0000;
      endcase
    end

    // Software writes; bits 31:3 of mode and 31:24 of the constant are dropped
    if (access_phase && pwrite_in) begin
      case (paddr_in)
        wdog_pkg::OFF_MODE_CONTROL: begin
          s_nxt.run_enable       = s_r.run_enable | pwdata_in[wdog_pkg::BIT_RUN_ENABLE];
          s_nxt.reset_on_timeout = s_r.reset_on_timeout | pwdata_in[wdog_pkg::BIT_RESET_ON_TIMEOUT];
          if (!pwdata_in[wdog_pkg::BIT_TIMEOUT_FLAG]) begin
            s_nxt.timeout_flag = 1'b0;
          end
        end
        wdog_pkg::OFF_TIMEOUT_CONST: s_nxt.timeout_constant = clamp_timeout(pwdata_in);
        default: s_nxt.timeout_constant = s_r.timeout_constant;
      endcase
    end

    // Feed sequence tracker; any access ends the sequence
    // A second first key counts as a wrong access, as does a read of any register
    if (access_phase) begin
      if (feed_write && (s_r.feed_state == wdog_pkg::FEED_IDLE) &&
          (pwdata_in[7:0] == wdog_pkg::FEED_KEY_FIRST)) begin
        s_nxt.feed_state = wdog_pkg::FEED_AFTER_FIRST;
      end else begin
        s_nxt.feed_state = wdog_pkg::FEED_IDLE;
      end
    end
    if (valid_feed) begin
      s_nxt.reload_pend = 1'b1;
    end

    // Errors count only once a feed has started the counter
    // One stage of delay puts the request in the second cycle after the bad access
    s_nxt.err_stage = feed_error && s_r.active.run;
    if (s_r.err_stage) begin
      if (s_r.active.reset_mode) begin
        s_nxt.chip_reset = 1'b1;
      end else begin
        s_nxt.interrupt_flag = 1'b1;
      end
    end

    // Counting side: acts only on counting-clock pulses
    // The prescaler is not cleared by a reload, so the first decrement after a
    // feed comes one to four pulses later; the timeout varies by one tick
    if (count_clock_en_in) begin
      s_nxt.snapshot = s_r.counter;
      if (s_r.reload_pend) begin
        // Mode bits are latched here, so a mode write waits for a feed
        s_nxt.reload_pend       = valid_feed;
        s_nxt.counter           = clamp_timeout({8'h00, tc_counting});
        s_nxt.active.run        = s_r.run_enable;
        s_nxt.active.reset_mode = s_r.reset_on_timeout;
      end else if (presc_tick && s_r.active.run) begin
        if (s_r.counter == 24'h00_0000) begin
          underflow     = 1'b1;
          s_nxt.counter = clamp_timeout({8'h00, tc_counting});
        end else begin
          s_nxt.counter = s_r.counter - 24'h00_0001;
        end
      end
    end

    // Underflow outcome; hardware sets win over software clears
    if (underflow) begin
      s_nxt.timeout_flag = 1'b1;
      if (s_r.active.reset_mode) begin
        s_nxt.chip_reset = 1'b1;
      end else begin
        s_nxt.interrupt_flag = 1'b1;
      end
      s_nxt.run_enable       = 1'b0;
      s_nxt.reset_on_timeout = 1'b0;
      s_nxt.active           = '0;
    end

    // Any system reset clears everything except the timeout flag
    // The prescaler and the constant pipeline keep running through it; a feed
    // within two pulses of a reset may still reload the old constant
    if (chip_reset_in) begin
      s_nxt                  = '0;
      s_nxt.timeout_constant = wdog_pkg::TIMEOUT_RESET;
      s_nxt.counter          = wdog_pkg::COUNT_RESET;
      s_nxt.snapshot         = wdog_pkg::COUNT_RESET;
      s_nxt.timeout_flag     = s_r.timeout_flag | underflow;
    end

    // Request held high until a system reset clears the interrupt flag
    s_nxt.irq  = s_nxt.interrupt_flag;
    s_nxt.wake = s_nxt.interrupt_flag && sleeping_in;
  end

  // ********************************************************************
  // Registers
  // ********************************************************************
  // Only power-on reset or a software write of 0 to the flag bit clears the timeout flag
  // Synchronous reset: the bus clock must run while rst_in is held
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      s_r                  <= '0;
      s_r.timeout_constant <= wdog_pkg::TIMEOUT_RESET;
      s_r.counter          <= wdog_pkg::COUNT_RESET;
      s_r.snapshot         <= wdog_pkg::COUNT_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  // Every output is a field of the state register, so none can glitch
  assign prdata_out         = s_r.answer.rdata;
  assign pready_out         = s_r.answer.ready;
  assign pslverr_out        = s_r.answer.slverr;
  assign chip_reset_req_out = s_r.chip_reset;
  assign irq_out            = s_r.irq;
  assign wake_out           = s_r.wake;

endmodule

`default_nettype wire

// ---- wdog_sva.sv ----
// Assertions on the watchdog bus answer and event pins.
// Assumes one bus clock and synchronous active-high rst_in.
`timescale 1ns/1ps
`default_nettype none
module wdog_sva (
  input wire logic        clock_in,
  input wire logic        rst_in,
  input wire logic        chip_reset_in,
  input wire logic        count_clock_en_in,
  input wire logic        sleeping_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic        chip_reset_req_out,
  input wire logic        irq_out,
  input wire logic        wake_out
);
  // ********************************
  // Properties
  // ********************************
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  // Only four word offsets answer without error
  wire logic mapped;
  assign mapped = (paddr_in[11:4] == 8'h00) && (paddr_in[1:0] == 2'h0);
  bus_answer_a: assert property (psel_in && !penable_in |=> pready_out)
    else $error("no answer after setup");
  answer_once_a: assert property (pready_out |=> !pready_out)
    else $error("answer longer than one cycle");
  unmapped_err_a: assert property (psel_in && !penable_in && !mapped |=>
    pslverr_out && prdata_out == 32'h0000_0000)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (psel_in && !penable_in && mapped |=> !pslverr_out)
    else $error("mapped access refused");
  irq_hold_a: assert property (irq_out && !chip_reset_in |=> irq_out)
    else $error("interrupt request dropped");
  req_hold_a: assert property (chip_reset_req_out && !chip_reset_in |=> chip_reset_req_out)
    else $error("reset request dropped");
  reset_clears_a: assert property (chip_reset_in |=> !irq_out && !chip_reset_req_out)
    else $error("system reset did not clear events");
  wake_set_a: assert property ((irq_out && sleeping_in) [*2] |-> wake_out)
    else $error("no wake while asleep");
  wake_clr_a: assert property (!$past(sleeping_in) && !sleeping_in |-> !wake_out)
    else $error("wake while awake");
endmodule
bind feed_sequenced_watchdog wdog_sva i_wdog_sva (.clock_in, .rst_in, .chip_reset_in, .count_clock_en_in,
  .sleeping_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out,
  .pslverr_out, .chip_reset_req_out, .irq_out, .wake_out);
`default_nettype wire

// ---- wdog_partner.sv ----
// Surroundings of the watchdog: counting-clock divider and system reset controller.
// Assumes the same bus clock; ext_reset_in is a bench-driven external reset.
`timescale 1ns/1ps
`default_nettype none
module wdog_partner (
  input  wire logic clock_in,
  input  wire logic rst_in,
  input  wire logic run_in,
  input  wire logic ext_reset_in,
  input  wire logic chip_reset_req_in,
  output logic      count_clock_en_out,
  output logic      chip_reset_out
);
  logic seen_r;
  // Counting pulse every second bus cycle; stops when run_in is low
  // One-cycle system reset answers each watchdog request
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      count_clock_en_out <= 1'b0;
      seen_r             <= 1'b0;
    end else begin
      count_clock_en_out <= run_in && !count_clock_en_out;
      seen_r             <= chip_reset_req_in && !seen_r;
    end
  end
  assign chip_reset_out = seen_r || ext_reset_in;
endmodule
`default_nettype wire

// ---- feed_sequenced_watchdog_test.sv ----
// Self-checking bench of the watchdog through its APB registers.
// Assumes the partner model supplies count pulses and system resets.
`timescale 1ns/1ps
`default_nettype none
module feed_sequenced_watchdog_test;
  logic clk, rst, ext_rst, run, chip_rst, cen, sleep_in;
  logic psel, pen, pwr, rdy, serr, req, irq, wake;
  logic [11:0] addr;
  logic [31:0] wdat, rdat, v;
  int errors, n_tests, cyc;
  wdog_partner i_wdog_partner (.clock_in(clk), .rst_in(rst), .run_in(run), .ext_reset_in(ext_rst),
    .chip_reset_req_in(req), .count_clock_en_out(cen), .chip_reset_out(chip_rst));
  feed_sequenced_watchdog i_feed_sequenced_watchdog (.clock_in(clk), .rst_in(rst),
    .chip_reset_in(chip_rst), .count_clock_en_in(cen), .sleeping_in(sleep_in), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(addr), .pwdata_in(wdat), .prdata_out(rdat),
    .pready_out(rdy), .pslverr_out(serr), .chip_reset_req_out(req), .irq_out(irq), .wake_out(wake));
  // ********************************
  // Clock, timeout and checks
  // ********************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Ceiling covers two full minimum timeouts with margin
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors = errors + 1;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // One APB transfer; request held until ready is sampled
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(negedge clk);
    psel = 1'b1;
    pwr  = w;
    addr = a;
    wdat = d;
    @(negedge clk);
    pen = 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k = k + 1;
    end while (rdy !== 1'b1 && k < 4);
    v = rdat;
    chk({31'h0, rdy}, 32'h1);
    chk({31'h0, serr}, {31'h0, (a > 12'h00c)});
    @(negedge clk);
    psel = 1'b0;
    pen  = 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(v, e);
  endtask
  task automatic feed();
    apb(1'b1, 12'h008, 32'h0000_00aa);
    apb(1'b1, 12'h008, 32'h0000_0055);
  endtask
  task automatic wait_on(input logic use_req);
    int k;
    k = 0;
    while ((use_req ? req : irq) !== 1'b1 && k < 3000) begin
      @(negedge clk);
      k = k + 1;
    end
    chk({31'h0, (use_req ? req : irq)}, 32'h1);
  endtask
  // ********************************
  // Test sequence
  // ********************************
  initial begin
    {ext_rst, psel, pen, pwr, sleep_in, errors, n_tests, cyc} = '0;
    addr = 12'h000;
    wdat = 32'h0;
    run  = 1'b1;
    rst  = 1'b1;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    rd(12'h000, 32'h0000_0000);
    rd(12'h004, 32'h0000_00ff);
    rd(12'h00c, 32'h0000_00ff);
    rd(12'h010, 32'h0000_0000);
    $display("reset values done");
    apb(1'b1, 12'h004, 32'hff00_0010);
    rd(12'h004, 32'h0000_00ff);
    apb(1'b1, 12'h004, 32'hff00_0100);
    rd(12'h004, 32'h0000_0100);
    $display("timeout constant done");
    apb(1'b1, 12'h000, 32'h0000_0001);
    repeat (100) @(negedge clk);
    rd(12'h00c, 32'h0000_00ff);
    apb(1'b1, 12'h008, 32'h0000_00aa);
    rd(12'h000, 32'h0000_0001);
    repeat (5) @(negedge clk);
    chk({30'h0, irq, req}, 32'h0);
    feed();
    repeat (100) @(negedge clk);
    apb(1'b0, 12'h00c, 32'h0);
    chk({31'h0, (v < 32'h0000_00fa) && (v > 32'h0000_00e8)}, 32'h1);
    apb(1'b1, 12'h000, 32'h0000_0000);
    rd(12'h000, 32'h0000_0001);
    wait_on(1'b0);
    chk({31'h0, req}, 32'h0);
    rd(12'h000, 32'h0000_000c);
    apb(1'b1, 12'h000, 32'h0000_0000);
    rd(12'h000, 32'h0000_0008);
    sleep_in = 1'b1;
    repeat (3) @(negedge clk);
    chk({30'h0, wake, irq}, 32'h3);
    sleep_in = 1'b0;
    $display("interrupt mode done");
    ext_rst = 1'b1;
    @(negedge clk);
    ext_rst = 1'b0;
    chk({31'h0, irq}, 32'h0);
    rd(12'h000, 32'h0000_0000);
    apb(1'b1, 12'h000, 32'h0000_0003);
    feed();
    apb(1'b1, 12'h008, 32'h0000_00aa);
    apb(1'b0, 12'h000, 32'h0);
    chk({31'h0, req}, 32'h0);
    @(negedge clk);
    chk({31'h0, req}, 32'h1);
    repeat (4) @(negedge clk);
    apb(1'b0, 12'h000, 32'h0);
    chk(v & 32'h0000_000b, 32'h0);
    $display("feed error done");
    apb(1'b1, 12'h000, 32'h0000_0000);
    apb(1'b1, 12'h000, 32'h0000_0003);
    feed();
    wait_on(1'b1);
    chk({31'h0, irq}, 32'h0);
    repeat (4) @(negedge clk);
    rd(12'h000, 32'h0000_0004);
    $display("reset mode done");
    end_sim();
  end
endmodule
`default_nettype wire
